// File: include/sfm_defines.svh
// Register map, field positions, reset values and timing constants of the sub-frame mask generator
`ifndef SFM_DEFINES_SVH
`define SFM_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define SFM_IDX_ILLUM_WIN   8'h9C
`define SFM_IDX_CALC_WIN    8'h9D
`define SFM_IDX_PDN_WIN     8'h9E
`define SFM_IDX_SF_COUNTS   8'h9F
`define SFM_IDX_CAPTURE     8'hA0
`define SFM_IDX_SF_LENGTH   8'hC0
`define SFM_IDX_CONTROL     8'hC1
`define SFM_IDX_STATUS      8'hC2

// ----------------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------------
`define SFM_REG_W           24
`define SFM_IDX_W           12
`define SFM_FIRST_LSB       0
`define SFM_LAST_LSB        12
`define SFM_POS_W           16
`define SFM_CTRL_RUN_BIT    0
`define SFM_CTRL_ACONF_BIT  1
`define SFM_STAT_RUN_BIT    12

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SFM_RST_ILLUM_WIN   24'hFFF000
`define SFM_RST_CALC_WIN    24'h000000
`define SFM_RST_PDN_WIN     24'h000000
`define SFM_RST_SF_COUNTS   24'h000000
`define SFM_RST_CAPTURE     24'h002198
`define SFM_RST_CONTROL     24'h000000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SFM_CLK_PERIOD_NS   40
`define SFM_SUBFRAME_NS     250000
`define SFM_SUBFRAME_CLKS   (`SFM_SUBFRAME_NS / `SFM_CLK_PERIOD_NS)

`endif

// File: include/sfm_pkg.sv
// Types shared by the sub-frame mask generator modules
package sfm_pkg;

	// Sequencer states, one-hot
	typedef enum logic [1:0] {
		SFM_IDLE = 2'b01,
		SFM_RUN  = 2'b10
	} sfm_state_t;

	// Sub-frame index and clock position types
	typedef logic [11:0] sfm_index_t;
	typedef logic [15:0] sfm_pos_t;
	typedef logic [23:0] sfm_word_t;

endpackage

// File: include/sfm_win_if.sv
// Carrier between the sequencer and one sub-frame window comparator
`timescale 1ns/1ps
`default_nettype none
interface sfm_win_if;
	import sfm_pkg::*;

	sfm_index_t index;    // Current sub-frame index
	sfm_index_t first;    // First sub-frame of window
	sfm_index_t last;     // Last sub-frame of window
	logic       in_win;   // Index lies in window

	modport cmp (input index, input first, input last, output in_win);
	modport user (output index, output first, output last, input in_win);
endinterface
`default_nettype wire

// File: hdl/sfm_win_cmp.sv
// Sub-frame window comparator: flags an index between first and last inclusive
`timescale 1ns/1ps
`default_nettype none
module sfm_win_cmp
	import sfm_pkg::*;
(
	sfm_win_if.cmp win    // Window bounds and result
);

	// ------------------------------------------------------------------------
	// Comparison
	// ------------------------------------------------------------------------
	// A first above last gives an empty window rather than a wrapped one
	assign win.in_win = (win.index >= win.first) && (win.index <= win.last);

endmodule
`default_nettype wire

// File: hdl/sfm_timing_gen.sv
// Sub-frame sequencer with masked timing signals and APB register file
//
// Summary of operation
// - Illumination allowed only from first to last sub-frame
// - Illumination last index resets to all ones
// - Calculation signal only inside its sub-frame window
// - Power-down asserted only outside its window
// - Average one more sub-frame than count field
// - Frame holds one more sub-frame than field
// - Sub-frame lasts programmed number of clocks
// - Capture at programmed clock position, reset 2198h
`timescale 1ns/1ps
`default_nettype none
`include "sfm_defines.svh"
module sfm_timing_gen
	import sfm_pkg::*;
(
	input  wire logic        CLK_I,            // Timing clock, 25 MHz
	input  wire logic        RST_I,            // Synchronous reset, active high
	input  wire logic        PSEL_I,           // APB select
	input  wire logic        PENABLE_I,        // APB enable
	input  wire logic        PWRITE_I,         // APB write
	input  wire logic [11:0] PADDR_I,          // APB byte address
	input  wire logic [31:0] PWDATA_I,         // APB write data
	output logic      [31:0] PRDATA_O,         // APB read data
	output logic             PREADY_O,         // APB ready
	output logic             PSLVERR_O,        // APB error on unmapped address
	output logic             ILLUM_EN_O,       // Illumination enable timing signal
	output logic             CALC_O,           // Calculation timing signal
	output logic             POWERDOWN_O,      // Dynamic power-down timing signal
	output logic             CAPTURE_O,        // Data capture pulse
	output logic             AVG_ACTIVE_O,     // Sub-frame belongs to averaged set
	output logic             FRAME_START_O,    // First clock of a frame
	output logic             SUBFRAME_START_O, // First clock of a sub-frame
	output logic      [11:0] SUBFRAME_INDEX_O  // Index of current sub-frame
);

	// ------------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------------

	// Lower index field of a window or count word
	function automatic sfm_index_t lo_field(input sfm_word_t w);
		lo_field = w[`SFM_FIRST_LSB +: `SFM_IDX_W];
	endfunction

	// Upper index field of a window or count word
	function automatic sfm_index_t hi_field(input sfm_word_t w);
		hi_field = w[`SFM_LAST_LSB +: `SFM_IDX_W];
	endfunction

	// Register index match against the word address
	function automatic logic hit(input logic [9:0] widx, input logic [7:0] ridx);
		hit = (widx == {2'h0, ridx});
	endfunction

	// ------------------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------------------
	sfm_word_t  illum_win;      // Illumination window, last and first
	sfm_word_t  calc_win;       // Calculation window
	sfm_word_t  pdn_win;        // Power-down window
	sfm_word_t  sf_counts;      // Averaged and total sub-frame counts
	sfm_pos_t   capture_pos;    // Capture clock position
	sfm_pos_t   sf_length;      // Sub-frame length in clocks
	logic       run_en;         // Sequencer run enable
	logic       aconf_off;      // Automatic timing configuration off

	// ------------------------------------------------------------------------
	// Decoded register fields
	// ------------------------------------------------------------------------
	sfm_index_t illum_window_first;
	sfm_index_t illum_window_last;
	sfm_index_t calc_window_first;
	sfm_index_t calc_window_last;
	sfm_index_t powerdown_window_first;
	sfm_index_t powerdown_window_last;
	sfm_index_t averaged_subframe_count;
	sfm_index_t total_subframe_count;

	// Field split of the window and count registers
	assign illum_window_first      = lo_field(illum_win);
	assign illum_window_last       = hi_field(illum_win);
	assign calc_window_first       = lo_field(calc_win);
	assign calc_window_last        = hi_field(calc_win);
	assign powerdown_window_first  = lo_field(pdn_win);
	assign powerdown_window_last   = hi_field(pdn_win);
	assign averaged_subframe_count = hi_field(sf_counts);
	assign total_subframe_count    = lo_field(sf_counts);

	// ------------------------------------------------------------------------
	// APB address decode
	// ------------------------------------------------------------------------
	logic [9:0] word_idx;
	logic       sel_illum;
	logic       sel_calc;
	logic       sel_pdn;
	logic       sel_counts;
	logic       sel_capture;
	logic       sel_length;
	logic       sel_control;
	logic       sel_status;
	logic       addr_ok;
	logic       access;
	logic       wr_en;
	logic       setup;

	// Word aligned index; the two low address bits are ignored
	assign word_idx    = PADDR_I[11:2];
	assign sel_illum   = hit(word_idx, `SFM_IDX_ILLUM_WIN);
	assign sel_calc    = hit(word_idx, `SFM_IDX_CALC_WIN);
	assign sel_pdn     = hit(word_idx, `SFM_IDX_PDN_WIN);
	assign sel_counts  = hit(word_idx, `SFM_IDX_SF_COUNTS);
	assign sel_capture = hit(word_idx, `SFM_IDX_CAPTURE);
	assign sel_length  = hit(word_idx, `SFM_IDX_SF_LENGTH);
	assign sel_control = hit(word_idx, `SFM_IDX_CONTROL);
	assign sel_status  = hit(word_idx, `SFM_IDX_STATUS);
	assign addr_ok     = sel_illum | sel_calc | sel_pdn | sel_counts
	                   | sel_capture | sel_length | sel_control | sel_status;

	// Access phase, write strobe and setup phase
	assign setup  = PSEL_I & ~PENABLE_I;
	assign access = PSEL_I & PENABLE_I;
	assign wr_en  = access & PWRITE_I & addr_ok;

	// Zero wait states: read data is staged in setup, so access can end at once
	assign PREADY_O  = access;
	assign PSLVERR_O = access & ~addr_ok;

	// ------------------------------------------------------------------------
	// Sequencer state and counters
	// ------------------------------------------------------------------------
	sfm_state_t state;
	sfm_state_t next_state;
	sfm_pos_t   clk_cnt;
	sfm_pos_t   next_clk_cnt;
	sfm_index_t sf_idx;
	sfm_index_t next_sf_idx;
	sfm_pos_t   len_last;
	logic       sf_end;
	logic       frame_end;
	logic       running;

	// ------------------------------------------------------------------------
	// Status readback
	// ------------------------------------------------------------------------
	sfm_word_t  status_word;
	sfm_word_t  ctrl_word;
	sfm_word_t  rd_mux;

	// Status shows the live index and whether the sequencer runs
	assign status_word = {11'h0, running, sf_idx};
	assign ctrl_word   = {22'h0, aconf_off, run_en};

	// Read selection; reserved capture bits always read zero
	assign rd_mux = sel_illum   ? illum_win :
	                sel_calc    ? calc_win :
	                sel_pdn     ? pdn_win :
	                sel_counts  ? sf_counts :
	                sel_capture ? {8'h00, capture_pos} :
	                sel_length  ? {8'h00, sf_length} :
	                sel_control ? ctrl_word :
	                sel_status  ? status_word :
	                24'h000000;

	// Read data captured in the setup cycle, held through the access phase
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			PRDATA_O <= 32'h00000000;
		end else if (setup && !PWRITE_I) begin
			PRDATA_O <= {8'h00, rd_mux};
		end
	end

	// ------------------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------------------
	// Window and count registers; illumination last resets to FFFh
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			illum_win <= `SFM_RST_ILLUM_WIN;
			calc_win  <= `SFM_RST_CALC_WIN;
			pdn_win   <= `SFM_RST_PDN_WIN;
			sf_counts <= `SFM_RST_SF_COUNTS;
		end else if (wr_en) begin
			if (sel_illum) begin
				illum_win <= PWDATA_I[`SFM_REG_W-1:0];
			end
			if (sel_calc) begin
				calc_win <= PWDATA_I[`SFM_REG_W-1:0];
			end
			if (sel_pdn) begin
				pdn_win <= PWDATA_I[`SFM_REG_W-1:0];
			end
			if (sel_counts) begin
				sf_counts <= PWDATA_I[`SFM_REG_W-1:0];
			end
		end
	end

	// Position, length and control; the capture upper byte is not stored
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			capture_pos <= sfm_pos_t'(`SFM_RST_CAPTURE);
			sf_length   <= sfm_pos_t'(`SFM_SUBFRAME_CLKS);
			run_en      <= 1'(`SFM_RST_CONTROL);
			aconf_off   <= 1'(`SFM_RST_CONTROL);
		end else if (wr_en) begin
			if (sel_capture) begin
				capture_pos <= PWDATA_I[`SFM_POS_W-1:0];
			end
			if (sel_length) begin
				sf_length <= PWDATA_I[`SFM_POS_W-1:0];
			end
			if (sel_control) begin
				run_en    <= PWDATA_I[`SFM_CTRL_RUN_BIT];
				aconf_off <= PWDATA_I[`SFM_CTRL_ACONF_BIT];
			end
		end
	end

	// ------------------------------------------------------------------------
	// Sub-frame timing
	// ------------------------------------------------------------------------
	// A length of zero is treated as one clock so the counter never stalls
	assign len_last  = (sf_length == 16'h0000) ? 16'h0000 : sf_length - 16'h0001;
	assign running   = (state == SFM_RUN);
	assign sf_end    = running && (clk_cnt == len_last);
	assign frame_end = sf_end && (sf_idx == total_subframe_count);

	// State decode: run follows the enable bit, stopping clears the counters
	always_comb begin
		next_state = state;
		unique case (state)
			SFM_IDLE: begin
				if (run_en) begin
					next_state = SFM_RUN;
				end
			end
			SFM_RUN: begin
				if (!run_en) begin
					next_state = SFM_IDLE;
				end
			end
			default: begin
				next_state = SFM_IDLE;
			end
		endcase
	end

	// Clock and index counters; index restarts at zero each frame
	always_comb begin
		next_clk_cnt = clk_cnt;
		next_sf_idx  = sf_idx;
		if (!running) begin
			next_clk_cnt = 16'h0000;
			next_sf_idx  = 12'h000;
		end else if (sf_end) begin
			next_clk_cnt = 16'h0000;
			next_sf_idx  = frame_end ? 12'h000 : sf_idx + 12'h001;
		end else begin
			next_clk_cnt = clk_cnt + 16'h0001;
		end
	end

	// Sequencer registers
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			state   <= SFM_IDLE;
			clk_cnt <= 16'h0000;
			sf_idx  <= 12'h000;
		end else begin
			state   <= next_state;
			clk_cnt <= next_clk_cnt;
			sf_idx  <= next_sf_idx;
		end
	end

	// ------------------------------------------------------------------------
	// Window comparators
	// ------------------------------------------------------------------------
	sfm_win_if illum_if ();
	sfm_win_if calc_if ();
	sfm_win_if pdn_if ();

	// Each window compares the live index with its bounds
	assign illum_if.index = sf_idx;
	assign illum_if.first = illum_window_first;
	assign illum_if.last  = illum_window_last;
	assign calc_if.index  = sf_idx;
	assign calc_if.first  = calc_window_first;
	assign calc_if.last   = calc_window_last;
	assign pdn_if.index   = sf_idx;
	assign pdn_if.first   = powerdown_window_first;
	assign pdn_if.last    = powerdown_window_last;

	sfm_win_cmp u_illum_cmp (
		.win (illum_if.cmp)
	);

	sfm_win_cmp u_calc_cmp (
		.win (calc_if.cmp)
	);

	sfm_win_cmp u_pdn_cmp (
		.win (pdn_if.cmp)
	);

	// ------------------------------------------------------------------------
	// Gated timing signals
	// ------------------------------------------------------------------------
	logic next_illum;
	logic next_calc;
	logic next_pdn;
	logic next_capture;
	logic next_avg;
	logic next_sf_start;
	logic next_fr_start;

	// Illumination only inside its window
	assign next_illum    = running && illum_if.in_win;
	// Calculation only inside its window
	assign next_calc     = running && calc_if.in_win;
	// Power-down only outside its window
	assign next_pdn      = running && !pdn_if.in_win;
	// A position past the sub-frame end never fires; software keeps it inside
	assign next_capture  = running && (clk_cnt == capture_pos);
	// Indices zero through the count field inclusive are averaged
	assign next_avg      = running && (sf_idx <= averaged_subframe_count);
	assign next_sf_start = running && (clk_cnt == 16'h0000);
	assign next_fr_start = next_sf_start && (sf_idx == 12'h000);

	// Outputs registered one clock behind the counters to keep them glitch free
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			ILLUM_EN_O       <= 1'b0;
			CALC_O           <= 1'b0;
			POWERDOWN_O      <= 1'b0;
			CAPTURE_O        <= 1'b0;
			AVG_ACTIVE_O     <= 1'b0;
			SUBFRAME_START_O <= 1'b0;
			FRAME_START_O    <= 1'b0;
			SUBFRAME_INDEX_O <= 12'h000;
		end else begin
			ILLUM_EN_O       <= next_illum;
			CALC_O           <= next_calc;
			POWERDOWN_O      <= next_pdn;
			CAPTURE_O        <= next_capture;
			AVG_ACTIVE_O     <= next_avg;
			SUBFRAME_START_O <= next_sf_start;
			FRAME_START_O    <= next_fr_start;
			SUBFRAME_INDEX_O <= sf_idx;
		end
	end

endmodule
`default_nettype wire

// File: verification/sfm_timing_gen_sva.sv
// Concurrent checks on the ports of the sub-frame mask generator
`timescale 1ns/1ps
`default_nettype none
`include "sfm_defines.svh"
module sfm_timing_gen_sva
	import sfm_pkg::*;
(
	input wire logic        CLK_I,            // Timing clock
	input wire logic        RST_I,            // Synchronous reset
	input wire logic        PSEL_I,           // APB select
	input wire logic        PENABLE_I,        // APB enable
	input wire logic        PWRITE_I,         // APB write
	input wire logic [11:0] PADDR_I,          // APB address
	input wire logic [31:0] PWDATA_I,         // APB write data
	input wire logic [31:0] PRDATA_O,         // APB read data
	input wire logic        PREADY_O,         // APB ready
	input wire logic        PSLVERR_O,        // APB error
	input wire logic        ILLUM_EN_O,       // Illumination enable
	input wire logic        CALC_O,           // Calculation signal
	input wire logic        POWERDOWN_O,      // Power-down signal
	input wire logic        CAPTURE_O,        // Capture pulse
	input wire logic        AVG_ACTIVE_O,     // Averaged sub-frame
	input wire logic        FRAME_START_O,    // Frame start pulse
	input wire logic        SUBFRAME_START_O, // Sub-frame start pulse
	input wire logic [11:0] SUBFRAME_INDEX_O  // Sub-frame index
);
	// ------------------------------------------------------------------
	// Shadow of the programmed fields, rebuilt from completed writes
	// ------------------------------------------------------------------
	wire logic [9:0] word = PADDR_I[11:2];
	wire logic       acc  = PSEL_I && PENABLE_I;
	wire logic       wr   = acc && PWRITE_I;
	sfm_word_t       illum, calc, pdn, counts;
	sfm_pos_t        cap, len, gap;
	logic            seen;
	wire sfm_index_t tot_f = counts[11:0];
	wire sfm_index_t avg_f = counts[23:12];
	wire sfm_pos_t   ilen  = (len == 16'h0000) ? 16'h0001 : len;

	function automatic logic inw(sfm_index_t i, sfm_word_t w);
		return i >= w[11:0] && i <= w[23:12];
	endfunction

	// Shadow registers follow the write strobe of the access phase
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			illum  <= `SFM_RST_ILLUM_WIN;
			calc   <= `SFM_RST_CALC_WIN;
			pdn    <= `SFM_RST_PDN_WIN;
			counts <= `SFM_RST_SF_COUNTS;
			cap    <= sfm_pos_t'(`SFM_RST_CAPTURE);
			len    <= sfm_pos_t'(`SFM_SUBFRAME_CLKS);
		end else if (wr) begin
			case (word)
				10'(`SFM_IDX_ILLUM_WIN): illum <= PWDATA_I[23:0];
				10'(`SFM_IDX_CALC_WIN):  calc <= PWDATA_I[23:0];
				10'(`SFM_IDX_PDN_WIN):   pdn <= PWDATA_I[23:0];
				10'(`SFM_IDX_SF_COUNTS): counts <= PWDATA_I[23:0];
				10'(`SFM_IDX_CAPTURE):   cap <= PWDATA_I[15:0];
				10'(`SFM_IDX_SF_LENGTH): len <= PWDATA_I[15:0];
				default: ;
			endcase
		end
	end

	// Clocks since the last sub-frame start; a control write forgets history
	always_ff @(posedge CLK_I) begin
		gap  <= SUBFRAME_START_O ? 16'h0001 : gap + 16'h0001;
		seen <= (RST_I || (wr && word == 10'(`SFM_IDX_CONTROL))) ? 1'b0 : (seen || SUBFRAME_START_O);
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	a_illum_window: assert property (ILLUM_EN_O |-> inw(SUBFRAME_INDEX_O, $past(illum)))
		else $error("illumination outside its window");
	a_calc_window: assert property (CALC_O |-> inw(SUBFRAME_INDEX_O, $past(calc)))
		else $error("calculation outside its window");
	a_pdn_outside: assert property (POWERDOWN_O |-> !inw(SUBFRAME_INDEX_O, $past(pdn)))
		else $error("power-down inside its window");
	a_avg_range: assert property (AVG_ACTIVE_O |-> SUBFRAME_INDEX_O <= $past(avg_f))
		else $error("averaging marker beyond count");
	a_frame_wrap: assert property (FRAME_START_O && seen |-> $past(SUBFRAME_INDEX_O) == $past(tot_f))
		else $error("frame wrapped at wrong index");
	a_frame_first: assert property (FRAME_START_O |-> SUBFRAME_START_O && SUBFRAME_INDEX_O == 12'h000)
		else $error("frame start not at sub-frame zero");
	a_index_step: assert property (SUBFRAME_START_O && !FRAME_START_O |->
		SUBFRAME_INDEX_O == $past(SUBFRAME_INDEX_O) + 12'h001)
		else $error("index did not advance by one");
	a_subframe_len: assert property (SUBFRAME_START_O && seen |-> gap == ilen)
		else $error("sub-frame length wrong");
	a_capture_pos: assert property (CAPTURE_O |-> (SUBFRAME_START_O ? 16'h0000 : gap) == $past(cap))
		else $error("capture at wrong clock");
	a_capture_read: assert property (acc && !PWRITE_I && word == 10'(`SFM_IDX_CAPTURE) |->
		PRDATA_O == {16'h0000, cap})
		else $error("capture register read wrong");
	a_stop_quiet: assert property (wr && word == 10'(`SFM_IDX_CONTROL) && !PWDATA_I[0] |->
		##3 !(ILLUM_EN_O || CALC_O || POWERDOWN_O || AVG_ACTIVE_O))
		else $error("outputs active after stop");

	c_frame: cover property (FRAME_START_O && seen);
	c_capture: cover property (CAPTURE_O && !SUBFRAME_START_O);
	c_pdn_pulse: cover property (POWERDOWN_O ##1 !POWERDOWN_O);
	c_slverr: cover property (acc && PSLVERR_O);
endmodule

bind sfm_timing_gen sfm_timing_gen_sva u_sva (.CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
	.PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .ILLUM_EN_O(ILLUM_EN_O),
	.CALC_O(CALC_O), .POWERDOWN_O(POWERDOWN_O), .CAPTURE_O(CAPTURE_O),
	.AVG_ACTIVE_O(AVG_ACTIVE_O), .FRAME_START_O(FRAME_START_O),
	.SUBFRAME_START_O(SUBFRAME_START_O), .SUBFRAME_INDEX_O(SUBFRAME_INDEX_O));
`default_nettype wire

// File: verification/tb_subframe_mask_timing_gen.sv
// Self-checking bench of the sub-frame mask generator
`timescale 1ns/1ps
`default_nettype none
`include "sfm_defines.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_subframe_mask_timing_gen;
	// ------------------------------------------------------------------
	// Signals and register addresses
	// ------------------------------------------------------------------
	localparam int A_ILL = `SFM_IDX_ILLUM_WIN * 4;
	localparam int A_CAL = `SFM_IDX_CALC_WIN * 4;
	localparam int A_PDN = `SFM_IDX_PDN_WIN * 4;
	localparam int A_CNT = `SFM_IDX_SF_COUNTS * 4;
	localparam int A_CAP = `SFM_IDX_CAPTURE * 4;
	localparam int A_LEN = `SFM_IDX_SF_LENGTH * 4;
	localparam int A_CTL = `SFM_IDX_CONTROL * 4;
	typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] r; logic e;} sfm_tb_row_t;

	logic             clk, rst, psel, penable, pwrite, rerr;
	logic [11:0]      paddr, sub_index;
	logic [31:0]      pwdata, prdata, rdat;
	logic             pready, pslverr, illum_en, calc, pdn, capture, avg_active, frame_start;
	logic             sub_start;
	int               bad_count, cmp_count, cyc;
	int               len, tot, avg, ilf, ill, caf, cal, pdf, pdl, pos;
	wire logic [18:0] outs = {sub_index, illum_en, calc, pdn, capture, avg_active, frame_start,
		sub_start};
	// Write value, expected readback, expected error
	sfm_tb_row_t      rows [9] = '{
		{12'h270, 32'h00ABC123, 32'h00ABC123, 1'b0}, {12'h274, 32'hFFFFFFFF, 32'h00FFFFFF, 1'b0},
		{12'h278, 32'h00555AAA, 32'h00555AAA, 1'b0}, {12'h27C, 32'h00002003, 32'h00002003, 1'b0},
		{12'h280, 32'h00001234, 32'h00001234, 1'b0}, {12'h300, 32'h0000ABCD, 32'h0000ABCD, 1'b0},
		{12'h400, 32'h12345678, 32'h00000000, 1'b1}, {12'h26C, 32'h00000FFF, 32'h00000000, 1'b1},
		{12'h308, 32'hFFFFFFFF, 32'h00000000, 1'b0}};

	sfm_timing_gen uut (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .ILLUM_EN_O(illum_en), .CALC_O(calc),
		.POWERDOWN_O(pdn), .CAPTURE_O(capture), .AVG_ACTIVE_O(avg_active),
		.FRAME_START_O(frame_start), .SUBFRAME_START_O(sub_start), .SUBFRAME_INDEX_O(sub_index));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Watchdog: the whole run needs well under two thousand clocks
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			final_report();
		end
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input int a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= 12'(a);
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rdat    = prdata;
		rerr    = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic inw(int s, int f, int l);
		return s >= f && s <= l;
	endfunction

	// Program the sequencer from the bench fields, then start it
	task automatic cfg(input logic wi);
		apb(1'b1, A_LEN, 32'(len));
		apb(1'b1, A_CNT, {8'h00, 12'(avg), 12'(tot)});
		if (wi)
			apb(1'b1, A_ILL, {8'h00, 12'(ill), 12'(ilf)});
		apb(1'b1, A_CAL, {8'h00, 12'(cal), 12'(caf)});
		apb(1'b1, A_PDN, {8'h00, 12'(pdl), 12'(pdf)});
		apb(1'b1, A_CAP, 32'(pos));
		// Automatic configuration stays on, so free windows are legal
		apb(1'b1, A_CTL, 32'h00000001);
	endtask

	// Compare every timing output, every clock, against the bench's own count
	task automatic check_frames(input int nf);
		int          c, sf, k;
		logic [18:0] ex;
		@(negedge clk);
		while (frame_start !== 1'b1)
			@(negedge clk);
		for (c = 0; c < nf * (tot + 1) * len; c++) begin
			sf = (c / len) % (tot + 1);
			k  = c % len;
			ex = {12'(sf), inw(sf, ilf, ill), inw(sf, caf, cal), !inw(sf, pdf, pdl), k == pos,
				sf <= avg, c % ((tot + 1) * len) == 0, k == 0};
			`CHK("timing outputs", ex, outs)
			@(negedge clk);
		end
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		rst     = 1'b1;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 12'h000;
		pwdata  = 32'h00000000;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].d);
			`CHK("write error", rows[i].e, rerr)
			apb(1'b0, rows[i].a, 32'h00000000);
			`CHK("readback", rows[i].r, rdat)
			`CHK("read error", rows[i].e, rerr)
		end
		$display("test register rows done");
		// Second reset must restore the illumination, capture, count and length fields
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		apb(1'b0, A_ILL, 32'h0);
		`CHK("illum reset", 32'h00FFF000, rdat)
		apb(1'b0, A_CAP, 32'h0);
		`CHK("capture reset", 32'h00002198, rdat)
		apb(1'b0, A_CNT, 32'h0);
		`CHK("counts reset", 32'h00000000, rdat)
		apb(1'b0, A_LEN, 32'h0);
		`CHK("length reset", 32'(`SFM_SUBFRAME_CLKS), rdat)
		$display("test reset values done");
		// Default illumination window, capture at clock zero
		len = 16; tot = 3; avg = 1; ilf = 0; ill = 4095;
		caf = 1; cal = 1; pdf = 0; pdl = 1; pos = 0;
		cfg(1'b0);
		check_frames(2);
		apb(1'b1, A_CTL, 32'h00000000);
		repeat (3) @(negedge clk);
		`CHK("stopped outputs", 19'h00000, outs)
		$display("test default window done");
		// Empty calculation window, capture at the last clock
		len = 7; tot = 4; avg = 2; ilf = 1; ill = 2;
		caf = 3; cal = 1; pdf = 1; pdl = 3; pos = 6;
		cfg(1'b1);
		check_frames(2);
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		`CHK("reset outputs", 19'h00000, outs)
		apb(1'b0, A_ILL, 32'h0);
		`CHK("illum after reset", 32'h00FFF000, rdat)
		$display("test windows and mid-run reset done");
		final_report();
	end
endmodule
`default_nettype wire
